// >>> verilog/ahc_defines.vh
`ifndef AHC_DEFINES_VH
`define AHC_DEFINES_VH

// Register map of the device's internal address space.
`define AHC_ADDR_X_LOW        8'h04
`define AHC_ADDR_X_HIGH       8'h05
`define AHC_ADDR_Y_LOW        8'h06
`define AHC_ADDR_Y_HIGH       8'h07
`define AHC_ADDR_Z_LOW        8'h08
`define AHC_ADDR_Z_HIGH       8'h09
`define AHC_ADDR_CONFIG       8'h19
`define AHC_ADDR_MAG_LOW      8'h32
`define AHC_ADDR_MAG_HIGH     8'h33
`define AHC_CONFIG_RESET      8'h00
`define AHC_CONFIG_WMASK      8'h1f

// Field positions of the sensor output and shutdown configuration register.
`define AHC_BIT_MAG_EN        4
`define AHC_BIT_X_SKIP        3
`define AHC_BIT_Y_SKIP        2
`define AHC_BIT_Z_SKIP        1
`define AHC_BIT_HIBERNATE     0

// Detector source code that selects the magnitude result.
`define AHC_DET_SRC_MAG       2'h1

// Power states.
`define AHC_PWR_STANDBY       2'h0
`define AHC_PWR_ACTIVE        2'h1
`define AHC_PWR_HIBERNATE     2'h2
`define AHC_PWR_BOOT          2'h3

// Internal boot delay in clock cycles.
`define AHC_BOOT_CYCLES       16'd1000

`endif

// >>> verilog/ahc_magnitude.v
`timescale 1ns/1ps
module ahc_magnitude (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Control
    input  wire        start,
    input  wire [11:0] x_in,
    input  wire [11:0] y_in,
    input  wire [11:0] z_in,
    // Result
    output reg         done_ff,
    output reg  [11:0] mag_ff
);

    // Square root of the sum of squares by the digit-by-digit method.
    // One result bit per cycle keeps area small; twelve cycles per sample.
    function [23:0] sq;
        input [11:0] v;
        reg   [11:0] a;
        begin
            a  = v[11] ? (~v + 12'h001) : v;
            sq = a * a;
        end
    endfunction

    reg  [25:0] rem_ff;
    reg  [11:0] root_ff;
    reg  [3:0]  cnt_ff;
    reg         busy_ff;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rem_ff  <= 26'h0;
            root_ff <= 12'h000;
            cnt_ff  <= 4'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            mag_ff  <= 12'h000;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                rem_ff  <= {2'h0, sq(x_in)} + {2'h0, sq(y_in)} + {2'h0, sq(z_in)};
                root_ff <= 12'h000;
                cnt_ff  <= 4'hc;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (({14'h0, root_ff | (12'h001 << (cnt_ff - 4'h1))} *
                     {14'h0, root_ff | (12'h001 << (cnt_ff - 4'h1))}) <= rem_ff)
                    root_ff <= root_ff | (12'h001 << (cnt_ff - 4'h1));
                cnt_ff <= cnt_ff - 4'h1;
                if (cnt_ff == 4'h1) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    if (({14'h0, root_ff | 12'h001} * {14'h0, root_ff | 12'h001}) <= rem_ff)
                        mag_ff <= root_ff | 12'h001;
                    else
                        mag_ff <= root_ff;
                end
            end
        end
    end

endmodule

// >>> verilog/ahc_top.v
// Summary of operation
// [RULE1] Magnitude enable bit 4 set computes 12-bit magnitude every data cycle; the code computes it only in the active power state.
// [RULE2] Magnitude byte registers join burst reads only while magnitude is enabled.
// [RULE3] Detector source setting 1 feeds the magnitude to the change detector.
// [RULE4] X skip bit 3 drops X registers from burst reads.
// [RULE5] Y skip bit 2 drops Y registers from burst reads.
// [RULE6] Z skip bit 1 drops Z registers from burst reads.
// [RULE7] Skip bits at zero keep the axis in every output mode.
// [RULE8] Hibernate bit zero leaves the wake and sleep power settings in charge.
// [RULE9] Writing hibernate bit one shuts down and clears all register contents; the code does this only with the strap low.
// [RULE10] Strap low: any edge on chip-select/wake pin leaves hibernate.
// [RULE11] Host waits the first boot delay after a wake edge.
// [RULE12] Strap high: motion input high boots straight to active mode.
// [RULE13] Host waits the second boot delay after motion input rises.
// [RULE14] Strap high: motion input low enters hibernate.
// [RULE15] Burst reads step past every excluded result register to the next.
`timescale 1ns/1ps
`include "ahc_defines.vh"
module ahc_top #(
    parameter BOOT_CYCLES = 1000
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst,
    // Register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire        reg_burst,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_ff,
    output reg  [7:0]  next_addr_ff,
    // Sample data
    input  wire        odr_tick,
    input  wire        buffered_mode,
    input  wire [11:0] x_data,
    input  wire [11:0] y_data,
    input  wire [11:0] z_data,
    input  wire [1:0]  detector_source,
    input  wire [1:0]  wake_power_setting,
    input  wire [1:0]  sleep_power_setting,
    // Pins
    input  wire        boot_strap_select,
    input  wire        cs_wake_pin,
    input  wire        motion_detect_input,
    // Status
    output reg  [11:0] detector_input_ff,
    output reg         mag_valid_ff,
    output reg  [1:0]  power_state_ff,
    output reg  [1:0]  power_setting_ff,
    output reg         comms_ready_ff,
    output reg  [7:0]  config_ff
);

    reg  [11:0] mag_hold_ff;
    reg  [15:0] boot_cnt_ff;
    reg         cs_level_ff;
    reg         strap_ff;
    reg         strap_seen_ff;
    reg  [1:0]  nxt_power;
    wire        mag_done;
    wire [11:0] mag_val;
    wire        magnitude_calc_enable;
    wire        x_axis_skip;
    wire        y_axis_skip;
    wire        z_axis_skip;
    wire        hib_write;

    assign magnitude_calc_enable = config_ff[`AHC_BIT_MAG_EN];
    assign x_axis_skip           = config_ff[`AHC_BIT_X_SKIP];
    assign y_axis_skip           = config_ff[`AHC_BIT_Y_SKIP];
    assign z_axis_skip           = config_ff[`AHC_BIT_Z_SKIP];
    assign hib_write = reg_wr && reg_addr == `AHC_ADDR_CONFIG && reg_wdata[`AHC_BIT_HIBERNATE] &&
                       comms_ready_ff && !strap_ff;

    // Tells whether an address is a result register left out of burst reads.
    function excluded;
        input [7:0] a;
        input [4:0] c;
        begin
            excluded = 1'b0;
            // [RULE4] X skip check.
            if ((a == `AHC_ADDR_X_LOW || a == `AHC_ADDR_X_HIGH) && c[`AHC_BIT_X_SKIP])
                excluded = 1'b1;
            // [RULE5] Y skip check.
            if ((a == `AHC_ADDR_Y_LOW || a == `AHC_ADDR_Y_HIGH) && c[`AHC_BIT_Y_SKIP])
                excluded = 1'b1;
            // [RULE6] Z skip check.
            if ((a == `AHC_ADDR_Z_LOW || a == `AHC_ADDR_Z_HIGH) && c[`AHC_BIT_Z_SKIP])
                excluded = 1'b1;
            // [RULE2] Magnitude bytes need enable.
            if ((a == `AHC_ADDR_MAG_LOW || a == `AHC_ADDR_MAG_HIGH) && !c[`AHC_BIT_MAG_EN])
                excluded = 1'b1;
        end
    endfunction

    // Next burst address; at most six excluded registers can sit in a row.
    function [7:0] step_addr;
        input [7:0] a;
        input [4:0] c;
        reg   [7:0] n;
        integer     i;
        begin
            n = a + 8'h01;
            for (i = 0; i < 7; i = i + 1) begin
                if (excluded(n, c))
                    n = n + 8'h01;
            end
            step_addr = n;
        end
    endfunction

    // [RULE1] Magnitude runs only when enabled.
    ahc_magnitude u_mag (
        .clock   (clock),
        .rst     (rst),
        .start   (odr_tick && magnitude_calc_enable && power_state_ff == `AHC_PWR_ACTIVE),
        .x_in    (x_data),
        .y_in    (y_data),
        .z_in    (z_data),
        .done_ff (mag_done),
        .mag_ff  (mag_val)
    );

    // Power state decisions.
    always @* begin
        nxt_power = power_state_ff;
        case (power_state_ff)
            `AHC_PWR_STANDBY, `AHC_PWR_ACTIVE: begin
                if (strap_ff) begin
                    // [RULE14] Motion low hibernates.
                    if (!motion_detect_input)
                        nxt_power = `AHC_PWR_HIBERNATE;
                end else if (hib_write) begin
                    // [RULE9] Hibernate command.
                    nxt_power = `AHC_PWR_HIBERNATE;
                end else if (power_state_ff == `AHC_PWR_STANDBY && wake_power_setting != 2'h0) begin
                    nxt_power = `AHC_PWR_ACTIVE;
                end
            end
            `AHC_PWR_HIBERNATE: begin
                // [RULE10] Either edge wakes.
                if (!strap_ff && cs_wake_pin != cs_level_ff)
                    nxt_power = `AHC_PWR_BOOT;
                // [RULE12] Motion high boots.
                if (strap_ff && motion_detect_input)
                    nxt_power = `AHC_PWR_BOOT;
            end
            `AHC_PWR_BOOT: begin
                if (boot_cnt_ff == 16'h0001)
                    nxt_power = strap_ff ? `AHC_PWR_ACTIVE : `AHC_PWR_STANDBY;
            end
            default: nxt_power = `AHC_PWR_STANDBY;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            power_state_ff    <= `AHC_PWR_BOOT;
            // The full boot delay also runs after reset, so the strap is caught before boot ends.
            boot_cnt_ff       <= BOOT_CYCLES[15:0];
            strap_ff          <= 1'b0;
            strap_seen_ff     <= 1'b0;
            cs_level_ff       <= 1'b1;
            config_ff         <= `AHC_CONFIG_RESET;
            reg_rdata_ff      <= 8'h00;
            next_addr_ff      <= 8'h00;
            mag_hold_ff       <= 12'h000;
            mag_valid_ff      <= 1'b0;
            detector_input_ff <= 12'h000;
            power_setting_ff  <= 2'h0;
            comms_ready_ff    <= 1'b0;
        end else begin
            // The strap is caught once after reset release.
            if (!strap_seen_ff) begin
                strap_ff      <= boot_strap_select;
                strap_seen_ff <= 1'b1;
            end
            power_state_ff <= nxt_power;
            // [RULE10] Remember wake level.
            if (nxt_power == `AHC_PWR_HIBERNATE && power_state_ff != `AHC_PWR_HIBERNATE)
                cs_level_ff <= cs_wake_pin;
            if (nxt_power == `AHC_PWR_BOOT && power_state_ff != `AHC_PWR_BOOT)
                boot_cnt_ff <= BOOT_CYCLES[15:0];
            else if (boot_cnt_ff != 16'h0000)
                boot_cnt_ff <= boot_cnt_ff - 16'h0001;
            // [RULE11] Ready only after boot delay.
            comms_ready_ff <= nxt_power == `AHC_PWR_STANDBY || nxt_power == `AHC_PWR_ACTIVE;

            // Clearing on the entry edge keeps the hibernate write itself from ever landing.
            // [RULE9] Contents lost on shutdown.
            if (nxt_power == `AHC_PWR_HIBERNATE || power_state_ff == `AHC_PWR_HIBERNATE) begin
                config_ff    <= `AHC_CONFIG_RESET;
                mag_hold_ff  <= 12'h000;
                mag_valid_ff <= 1'b0;
            end else begin
                if (reg_wr && comms_ready_ff && reg_addr == `AHC_ADDR_CONFIG)
                    config_ff <= reg_wdata & `AHC_CONFIG_WMASK;
                if (mag_done) begin
                    mag_hold_ff  <= mag_val;
                    mag_valid_ff <= 1'b1;
                end
                if (!magnitude_calc_enable)
                    mag_valid_ff <= 1'b0;
            end

            // [RULE3] Detector source select.
            if (detector_source == `AHC_DET_SRC_MAG)
                detector_input_ff <= mag_hold_ff;
            else
                detector_input_ff <= x_data;

            // [RULE8] Wake setting applies in active on a data tick, sleep setting in standby.
            if (power_state_ff == `AHC_PWR_ACTIVE)
                power_setting_ff <= odr_tick ? wake_power_setting : power_setting_ff;
            else if (power_state_ff == `AHC_PWR_STANDBY)
                power_setting_ff <= sleep_power_setting;

            if (reg_rd && comms_ready_ff) begin
                case (reg_addr)
                    `AHC_ADDR_CONFIG:    reg_rdata_ff <= config_ff;
                    `AHC_ADDR_X_LOW:     reg_rdata_ff <= x_data[7:0];
                    `AHC_ADDR_X_HIGH:    reg_rdata_ff <= {4'h0, x_data[11:8]};
                    `AHC_ADDR_Y_LOW:     reg_rdata_ff <= y_data[7:0];
                    `AHC_ADDR_Y_HIGH:    reg_rdata_ff <= {4'h0, y_data[11:8]};
                    `AHC_ADDR_Z_LOW:     reg_rdata_ff <= z_data[7:0];
                    `AHC_ADDR_Z_HIGH:    reg_rdata_ff <= {4'h0, z_data[11:8]};
                    `AHC_ADDR_MAG_LOW:   reg_rdata_ff <= mag_hold_ff[7:0];
                    `AHC_ADDR_MAG_HIGH:  reg_rdata_ff <= {4'h0, mag_hold_ff[11:8]};
                    default:             reg_rdata_ff <= 8'h00;
                endcase
                // [RULE15] Skip excluded results. [RULE7] Zero bits keep axes in any mode.
                if (reg_burst)
                    next_addr_ff <= step_addr(reg_addr, config_ff[4:0]);
                else
                    next_addr_ff <= reg_addr + 8'h01;
            end
        end
    end

endmodule

// >>> sim/ahc_asserts.sv
`timescale 1ns/1ps
`include "ahc_defines.vh"
module ahc_asserts (
    // Clock and reset
    input wire       clock,
    input wire       rst,
    // Register port
    input wire       reg_wr,
    input wire       reg_rd,
    input wire       reg_burst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] next_addr_ff,
    // Samples, pins and status
    input wire       odr_tick,
    input wire       boot_strap_select,
    input wire       cs_wake_pin,
    input wire       motion_detect_input,
    input wire       mag_valid_ff,
    input wire [1:0] power_state_ff,
    input wire       comms_ready_ff,
    input wire [7:0] config_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire rd_ok;
    wire hib;
    assign rd_ok = reg_rd && reg_burst && comms_ready_ff;
    assign hib = power_state_ff == `AHC_PWR_HIBERNATE;

    chk_hib_entry: assert property (reg_wr && comms_ready_ff && reg_addr == `AHC_ADDR_CONFIG && reg_wdata[0]
        && !boot_strap_select |=> hib) else $error("hibernate not entered");
    chk_cfg_lost: assert property (hib |-> config_ff == 8'h00) else $error("config kept in hibernate");
    chk_mag_run: assert property (odr_tick && config_ff[4] && power_state_ff == `AHC_PWR_ACTIVE
        |-> ##[1:16] mag_valid_ff) else $error("magnitude not produced");
    chk_skip_mag: assert property (rd_ok && !config_ff[4] |=> next_addr_ff != 8'h32 && next_addr_ff != 8'h33)
        else $error("magnitude in burst while off");
    chk_skip_x: assert property (rd_ok && config_ff[3] |=> next_addr_ff != 8'h04 && next_addr_ff != 8'h05)
        else $error("x in burst while skipped");
    chk_skip_y: assert property (rd_ok && config_ff[2] |=> next_addr_ff != 8'h06 && next_addr_ff != 8'h07)
        else $error("y in burst while skipped");
    chk_skip_z: assert property (rd_ok && config_ff[1] |=> next_addr_ff != 8'h08 && next_addr_ff != 8'h09)
        else $error("z in burst while skipped");
    chk_wake_edge: assert property (!boot_strap_select && hib && $changed(cs_wake_pin)
        |-> ##[1:3] power_state_ff == `AHC_PWR_BOOT) else $error("wake edge ignored");
    chk_motion_low: assert property (boot_strap_select && !motion_detect_input
        && power_state_ff == `AHC_PWR_ACTIVE |-> ##[1:3] hib) else $error("motion low kept device up");
endmodule

// >>> sim/ahc_host.sv
`timescale 1ns/1ps
module ahc_host (
    // Clock
    input wire       clock,
    // Register port
    output reg       reg_wr,
    output reg       reg_rd,
    output reg       reg_burst,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata_ff
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_burst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Callers only start once the device reports ready.
    // Released address and data lines show the inverse of the last value so stale data cannot pass.
    task automatic access(input wr, input [7:0] a, input [7:0] d, output [7:0] q);
        @(negedge clock);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_burst <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(negedge clock);
        q = reg_rdata_ff;
    endtask
endmodule

// >>> sim/axis_range_and_hibernate_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "ahc_defines.vh"
module axis_range_and_hibernate_ctrl_tb_top;
    reg         clock = 1'b0;
    reg         rst = 1'b1;
    reg         odr_tick = 1'b0;
    reg         buffered_mode = 1'b0;
    reg  [11:0] x_data = 12'h003;
    reg  [11:0] y_data = 12'h004;
    reg  [11:0] z_data = 12'h00c;
    reg  [1:0]  detector_source = 2'h1;
    reg  [1:0]  wake_power_setting = 2'h1;
    reg  [1:0]  sleep_power_setting = 2'h2;
    reg         boot_strap_select = 1'b0;
    reg         cs_wake_pin = 1'b1;
    reg         motion_detect_input = 1'b1;
    wire        reg_wr, reg_rd, reg_burst, mag_valid_ff, comms_ready_ff;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata_ff, next_addr_ff, config_ff;
    wire [11:0] detector_input_ff;
    wire [1:0]  power_state_ff, power_setting_ff;
    integer     n_errors = 0;
    integer     cmp_count = 0;
    integer     cycles = 0;
    reg  [7:0]  q;

    always #12.5 clock = ~clock;

    ahc_top #(.BOOT_CYCLES(10)) uut (.clock, .rst, .reg_wr, .reg_rd, .reg_burst, .reg_addr, .reg_wdata,
        .reg_rdata_ff, .next_addr_ff, .odr_tick, .buffered_mode, .x_data, .y_data, .z_data, .detector_source,
        .wake_power_setting, .sleep_power_setting, .boot_strap_select, .cs_wake_pin, .motion_detect_input,
        .detector_input_ff, .mag_valid_ff, .power_state_ff, .power_setting_ff, .comms_ready_ff, .config_ff);
    ahc_host host (.clock, .reg_wr, .reg_rd, .reg_burst, .reg_addr, .reg_wdata, .reg_rdata_ff);

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            report_and_stop;
        end
    end

    task automatic check(input string what, input [11:0] seen, input [11:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input [7:0] a, input [7:0] d);
        host.access(1'b1, a, d, q);
    endtask

    task automatic rd(input [7:0] a);
        host.access(1'b0, a, 8'h00, q);
    endtask

    task automatic wait_ready;
        integer i;
        for (i = 0; i < 100 && comms_ready_ff !== 1'b1; i = i + 1)
            @(negedge clock);
        check("comms ready", comms_ready_ff, 1'b1);
    endtask

    task automatic do_reset(input strap);
        @(negedge clock);
        rst = 1'b1;
        boot_strap_select = strap;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        wait_ready;
    endtask

    task automatic pulse_tick;
        odr_tick = 1'b1;
        @(negedge clock);
        odr_tick = 1'b0;
    endtask

    task automatic t_reset;
        rd(`AHC_ADDR_CONFIG);
        check("cfg reset", q, 8'h00);
        wr(`AHC_ADDR_CONFIG, 8'h1e);
        rd(`AHC_ADDR_CONFIG);
        check("cfg rw", q, 8'h1e);
        check("no hibernate", power_state_ff, `AHC_PWR_ACTIVE);
    endtask

    task automatic t_mag;
        integer i;
        wr(`AHC_ADDR_CONFIG, 8'h00);
        pulse_tick;
        repeat (20) @(negedge clock);
        check("mag idle", mag_valid_ff, 1'b0);
        check("wake setting", power_setting_ff, 2'h1);
        wr(`AHC_ADDR_CONFIG, 8'h10);
        pulse_tick;
        for (i = 0; i < 20 && mag_valid_ff !== 1'b1; i = i + 1)
            @(negedge clock);
        repeat (2) @(negedge clock);
        check("detector in", detector_input_ff, 12'h00d);
        rd(`AHC_ADDR_MAG_LOW);
        check("mag low", q, 8'h0d);
        detector_source = 2'h0;
        repeat (2) @(negedge clock);
        check("detector x", detector_input_ff, 12'h003);
        detector_source = 2'h1;
    endtask

    task automatic t_burst;
        reg [23:0] tbl [0:5];
        integer i;
        tbl[0] = 24'h00_05_06;
        tbl[1] = 24'h04_05_08;
        tbl[2] = 24'h12_07_0a;
        tbl[3] = 24'h0e_03_0a;
        tbl[4] = 24'h00_31_34;
        tbl[5] = 24'h10_31_32;
        for (i = 0; i < 6; i = i + 1) begin
            buffered_mode = i[0];
            wr(`AHC_ADDR_CONFIG, tbl[i][23:16]);
            rd(tbl[i][15:8]);
            check("burst next", next_addr_ff, tbl[i][7:0]);
        end
        wr(`AHC_ADDR_CONFIG, 8'h00);
        rd(`AHC_ADDR_Y_LOW);
        check("y low", q, 8'h04);
    endtask

    task automatic t_hib_low;
        wr(`AHC_ADDR_CONFIG, 8'h11);
        check("hib state", power_state_ff, `AHC_PWR_HIBERNATE);
        check("cfg lost", config_ff, 8'h00);
        repeat (4) @(negedge clock);
        cs_wake_pin = 1'b0;
        repeat (2) @(negedge clock);
        wait_ready;
        check("woke", power_state_ff, `AHC_PWR_STANDBY);
        rd(`AHC_ADDR_CONFIG);
        check("cfg after wake", q, 8'h00);
        check("sleep setting", power_setting_ff, 2'h2);
    endtask

    task automatic t_strap_high;
        do_reset(1'b1);
        check("strap boot", power_state_ff, `AHC_PWR_ACTIVE);
        motion_detect_input = 1'b0;
        repeat (4) @(negedge clock);
        check("motion low", power_state_ff, `AHC_PWR_HIBERNATE);
        motion_detect_input = 1'b1;
        repeat (2) @(negedge clock);
        wait_ready;
        check("motion high", power_state_ff, `AHC_PWR_ACTIVE);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        do_reset(1'b0);
        t_reset;
        t_mag;
        t_burst;
        t_hib_low;
        t_strap_high;
        report_and_stop;
    end
endmodule

bind ahc_top ahc_asserts u_chk (.clock, .rst, .reg_wr, .reg_rd, .reg_burst, .reg_addr, .reg_wdata, .next_addr_ff,
    .odr_tick, .boot_strap_select, .cs_wake_pin, .motion_detect_input, .mag_valid_ff, .power_state_ff,
    .comms_ready_ff, .config_ff);
